//--- hw/tcm_channel.sv
// Timer channel status/control register, mode decode, capture and pin logic.
// Function
// - Capture edge sets the channel event flag
// - Compare or edge PWM match sets flag
// - Center PWM sets flag on every match
// - Interrupt request when flag and enable set
// - Flag clears by read then write zero
// - New event restarts the clear sequence
// - Reset clears flag, writing one ignored
// - Interrupt enable bit six, read write
// - Upper mode bit selects edge PWM
// - Lower mode bit selects capture or compare
// - Edge level zero releases the pin
// - Capture edge chosen by edge level pattern
// - Compare pin action chosen by pattern
// - Edge PWM polarity chosen by pattern
// - Center PWM polarity chosen by pattern
// - Center mode select overrides channel modes
// - Capture copies counter into channel value
`timescale 1ns/1ps
module tcm_channel
    import tcm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] counter_value,
    input wire logic counter_match,
    input wire logic counter_overflow,
    input wire logic counter_down,
    input wire logic center_pwm_select,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic channel_irq
);

    typedef struct packed {
        logic rst_sync1;
        logic rst_sync2;
    } tcm_rst_t;

    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_enable;
        logic mode_select_upper;
        logic mode_select_lower;
        logic [1:0] edge_level_select;
        logic clear_armed;
        logic [15:0] channel_value;
        logic out_level;
        logic [31:0] rdata;
    } tcm_state_t;

    tcm_rst_t rst_reg;
    tcm_state_t state_reg;
    tcm_state_t state_next;
    tcm_apb_req_t req;
    tcm_counter_t cnt;
    tcm_mode_t mode;
    logic rst_n;
    logic rise;
    logic fall;
    logic capture_hit;
    logic event_hit;
    logic setup_phase;
    logic access_phase;
    logic wr_ctrl;
    logic wr_value;
    logic rd_ctrl;
    logic addr_ok;
    logic pin_used;
    logic [7:0] ctrl_view;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_reg <= '0;
        end else begin
            rst_reg.rst_sync1 <= 1'b1;
            rst_reg.rst_sync2 <= rst_reg.rst_sync1;
        end
    end

    assign rst_n = rst_reg.rst_sync2;

    tcm_edge_detect u_edge (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(pin_in),
        .rise(rise),
        .fall(fall)
    );

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign cnt = '{count: counter_value, match: counter_match, overflow: counter_overflow,
                   count_down: counter_down, center_pwm_select: center_pwm_select};

    // Center mode wins over the channel's own mode bits.
    always_comb begin
        if (cnt.center_pwm_select) begin
            mode = TCM_MODE_CPWM;
        end else if (state_reg.mode_select_upper) begin
            mode = TCM_MODE_EPWM;
        end else if (state_reg.mode_select_lower) begin
            mode = TCM_MODE_COMPARE;
        end else begin
            mode = TCM_MODE_CAPTURE;
        end
    end

    assign pin_used = state_reg.edge_level_select != TCM_ELS_OFF;

    // Active edge per edge/level pattern.
    always_comb begin
        case (state_reg.edge_level_select)
            TCM_ELS_01: capture_hit = rise;
            TCM_ELS_10: capture_hit = fall;
            TCM_ELS_11: capture_hit = rise | fall;
            default: capture_hit = 1'b0;
        endcase
    end

    always_comb begin
        case (mode)
            TCM_MODE_CAPTURE: event_hit = capture_hit;
            TCM_MODE_COMPARE: event_hit = cnt.match;
            TCM_MODE_EPWM: event_hit = cnt.match;
            TCM_MODE_CPWM: event_hit = cnt.match;
            default: event_hit = 1'b0;
        endcase
    end

    assign setup_phase = req.psel & ~req.penable;
    assign access_phase = req.psel & req.penable;
    assign addr_ok = (req.paddr == TCM_ADDR_CTRL) | (req.paddr == TCM_ADDR_VALUE)
                   | (req.paddr == TCM_ADDR_STATUS);
    assign wr_ctrl = access_phase & req.pwrite & (req.paddr == TCM_ADDR_CTRL);
    assign wr_value = access_phase & req.pwrite & (req.paddr == TCM_ADDR_VALUE);
    assign rd_ctrl = access_phase & ~req.pwrite & (req.paddr == TCM_ADDR_CTRL);

    assign ctrl_view = {state_reg.channel_event_flag, state_reg.channel_irq_enable,
                        state_reg.mode_select_upper, state_reg.mode_select_lower,
                        state_reg.edge_level_select, 2'h0};

    always_comb begin
        state_next = state_reg;
        // Clear sequence: a read that sees the flag arms it, a zero write then clears.
        if (rd_ctrl && state_reg.channel_event_flag) begin
            state_next.clear_armed = 1'b1;
        end
        if (wr_ctrl) begin
            state_next.channel_irq_enable = req.pwdata[TCM_BIT_IRQ_EN];
            state_next.mode_select_upper = req.pwdata[TCM_BIT_MS_UPPER];
            state_next.mode_select_lower = req.pwdata[TCM_BIT_MS_LOWER];
            state_next.edge_level_select = req.pwdata[TCM_BIT_ELS_HI:TCM_BIT_ELS_LO];
            state_next.clear_armed = 1'b0;
            if (!req.pwdata[TCM_BIT_FLAG] && state_reg.clear_armed) begin
                state_next.channel_event_flag = 1'b0;
            end
        end
        if (wr_value) begin
            state_next.channel_value = req.pwdata[15:0];
        end
        // A new event wins over a clear and restarts the sequence.
        if (event_hit) begin
            state_next.channel_event_flag = 1'b1;
            state_next.clear_armed = 1'b0;
        end
        if (mode == TCM_MODE_CAPTURE && capture_hit) begin
            state_next.channel_value = cnt.count;
        end
        case (mode)
            TCM_MODE_COMPARE: begin
                if (cnt.match) begin
                    case (state_reg.edge_level_select)
                        TCM_ELS_01: state_next.out_level = ~state_reg.out_level;
                        TCM_ELS_10: state_next.out_level = 1'b0;
                        TCM_ELS_11: state_next.out_level = 1'b1;
                        default: state_next.out_level = state_reg.out_level;
                    endcase
                end
            end
            TCM_MODE_EPWM: begin
                if (cnt.match) begin
                    state_next.out_level = state_reg.edge_level_select[0];
                end else if (cnt.overflow) begin
                    state_next.out_level = ~state_reg.edge_level_select[0];
                end
            end
            TCM_MODE_CPWM: begin
                if (cnt.match) begin
                    if (cnt.count_down) begin
                        state_next.out_level = ~state_reg.edge_level_select[0];
                    end else begin
                        state_next.out_level = state_reg.edge_level_select[0];
                    end
                end
            end
            default: state_next.out_level = state_reg.out_level;
        endcase
        state_next.rdata = 32'h0000_0000;
        if (setup_phase && !req.pwrite) begin
            case (req.paddr)
                TCM_ADDR_CTRL: state_next.rdata = {24'h00_0000, ctrl_view};
                TCM_ADDR_VALUE: state_next.rdata = {16'h0000, state_reg.channel_value};
                TCM_ADDR_STATUS: state_next.rdata = {28'h000_0000, mode};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end else begin
            state_next.rdata = state_reg.rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{channel_event_flag: 1'b0, channel_irq_enable: 1'b0,
                           mode_select_upper: 1'b0, mode_select_lower: 1'b0,
                           edge_level_select: 2'h0, clear_armed: 1'b0,
                           channel_value: TCM_VALUE_RESET, out_level: 1'b0,
                           rdata: 32'h0000_0000};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pready = 1'b1;
    assign pslverr = access_phase & ~addr_ok;
    assign prdata = state_reg.rdata;
    assign channel_irq = state_reg.channel_event_flag & state_reg.channel_irq_enable;
    assign pin_oe = pin_used & (mode != TCM_MODE_CAPTURE);
    assign pin_out = pin_oe & state_reg.out_level;

    a_irq_follows_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        channel_irq == (state_reg.channel_event_flag && state_reg.channel_irq_enable))
        else $error("Interrupt does not follow flag and enable.");

    a_event_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        event_hit |=> state_reg.channel_event_flag && !state_reg.clear_armed)
        else $error("Event did not set the flag.");

    a_flag_clear_needs_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(state_reg.channel_event_flag) |-> $past(wr_ctrl) && $past(state_reg.clear_armed))
        else $error("Flag cleared without read and zero write.");

    a_write_one_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && req.pwdata[TCM_BIT_FLAG] && state_reg.channel_event_flag
        |=> state_reg.channel_event_flag)
        else $error("Writing one cleared the flag.");

    a_center_override: assert property (@(posedge core_clk) disable iff (!rst_n)
        cnt.center_pwm_select |-> mode == TCM_MODE_CPWM)
        else $error("Center mode did not override channel mode.");

    a_pin_released: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg.edge_level_select == TCM_ELS_OFF |-> !pin_oe && !capture_hit)
        else $error("Pin used with edge level zero.");

    a_capture_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_CAPTURE && capture_hit |=> state_reg.channel_value == $past(cnt.count))
        else $error("Capture did not copy the counter.");

    a_epwm_match_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_EPWM && cnt.match
        |=> state_reg.out_level == $past(state_reg.edge_level_select[0]))
        else $error("Edge PWM level wrong after match.");

    a_epwm_overflow: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_EPWM && cnt.overflow && !cnt.match
        |=> state_reg.out_level != $past(state_reg.edge_level_select[0]))
        else $error("Edge PWM not active after overflow.");

    a_oc_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_COMPARE && cnt.match && state_reg.edge_level_select == TCM_ELS_11
        |=> state_reg.out_level)
        else $error("Compare set action failed.");

    a_capture_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_CAPTURE && capture_hit
        |=> state_reg.channel_event_flag)
        else $error("Capture edge did not set the flag.");

    a_compare_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == TCM_MODE_COMPARE || mode == TCM_MODE_EPWM) && cnt.match
        |=> state_reg.channel_event_flag)
        else $error("Compare match did not set the flag.");

    a_center_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_CPWM && cnt.match
        |=> state_reg.channel_event_flag)
        else $error("Center match did not set the flag.");

    a_zero_write_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && !req.pwdata[TCM_BIT_FLAG] && state_reg.clear_armed && !event_hit
        |=> !state_reg.channel_event_flag)
        else $error("Armed zero write did not clear the flag.");

    a_irq_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl
        |=> state_reg.channel_irq_enable == $past(req.pwdata[TCM_BIT_IRQ_EN]))
        else $error("Interrupt enable not written.");

    a_epwm_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cnt.center_pwm_select && state_reg.mode_select_upper
        |-> mode == TCM_MODE_EPWM)
        else $error("Upper mode bit did not select edge PWM.");

    a_lower_mode_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        !cnt.center_pwm_select && !state_reg.mode_select_upper
        |-> mode == (state_reg.mode_select_lower ? TCM_MODE_COMPARE : TCM_MODE_CAPTURE))
        else $error("Lower mode bit decoded wrongly.");

    a_rise_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg.edge_level_select == TCM_ELS_01 && fall
        |-> !capture_hit)
        else $error("Falling edge captured in rising only setting.");

    a_oc_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_COMPARE && cnt.match && state_reg.edge_level_select == TCM_ELS_01
        |=> state_reg.out_level != $past(state_reg.out_level))
        else $error("Compare toggle action failed.");

    a_oc_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_COMPARE && cnt.match && state_reg.edge_level_select == TCM_ELS_10
        |=> !state_reg.out_level)
        else $error("Compare clear action failed.");

    a_cpwm_up_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_CPWM && cnt.match && !cnt.count_down
        |=> state_reg.out_level == $past(state_reg.edge_level_select[0]))
        else $error("Center PWM level wrong after up match.");

    a_cpwm_down_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        mode == TCM_MODE_CPWM && cnt.match && cnt.count_down
        |=> state_reg.out_level != $past(state_reg.edge_level_select[0]))
        else $error("Center PWM level wrong after down match.");

endmodule : tcm_channel

//--- hw/tcm_edge_detect.sv
// Pin synchroniser and edge detector for the channel input.
`timescale 1ns/1ps
module tcm_edge_detect
    import tcm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
    } tcm_edge_state_t;

    tcm_edge_state_t state_reg;
    tcm_edge_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        state_next.last = state_reg.sync2;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise = state_reg.sync2 & ~state_reg.last;
    assign fall = ~state_reg.sync2 & state_reg.last;

endmodule : tcm_edge_detect

//--- hw/tcm_pkg.sv
// Package with register layout, modes and bus types of the timer channel control block.
package tcm_pkg;

    localparam logic [11:0] TCM_ADDR_CTRL = 12'h000;
    localparam logic [11:0] TCM_ADDR_VALUE = 12'h004;
    localparam logic [11:0] TCM_ADDR_STATUS = 12'h008;

    localparam int TCM_BIT_FLAG = 7;
    localparam int TCM_BIT_IRQ_EN = 6;
    localparam int TCM_BIT_MS_UPPER = 5;
    localparam int TCM_BIT_MS_LOWER = 4;
    localparam int TCM_BIT_ELS_HI = 3;
    localparam int TCM_BIT_ELS_LO = 2;

    localparam logic [7:0] TCM_CTRL_RESET = 8'h00;
    localparam logic [15:0] TCM_VALUE_RESET = 16'h0000;
    localparam logic [1:0] TCM_ELS_OFF = 2'h0;
    localparam logic [1:0] TCM_ELS_01 = 2'h1;
    localparam logic [1:0] TCM_ELS_10 = 2'h2;
    localparam logic [1:0] TCM_ELS_11 = 2'h3;

    typedef enum logic [3:0] {
        TCM_MODE_CAPTURE = 4'b0001,
        TCM_MODE_COMPARE = 4'b0010,
        TCM_MODE_EPWM = 4'b0100,
        TCM_MODE_CPWM = 4'b1000
    } tcm_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tcm_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tcm_apb_rsp_t;

    typedef struct packed {
        logic [15:0] count;
        logic match;
        logic overflow;
        logic count_down;
        logic center_pwm_select;
    } tcm_counter_t;

endpackage : tcm_pkg

//--- testbench/tb.sv
// Self-checking testbench for the timer channel control block.
`timescale 1ns/1ps
module tb;
    import tcm_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_level = 1'b0;
    logic pin_in, pin_out, pin_oe, channel_irq, fl;
    tcm_apb_req_t req = '0;
    tcm_apb_rsp_t rsp;
    tcm_counter_t cnt = '0;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h4b70d757;
    logic [32:0] exp_q[$];
    logic [2:0] pin_q[$];
    logic [2:0] pin_exp;
    logic [15:0] cap;
    logic [15:0] vexp = 16'h0000;
    logic [31:0] ctl;
    logic lvl = 1'b0;

    always #5 core_clk = ~core_clk;

    tcm_channel i_tcm_channel (.core_clk(core_clk), .rstn(rstn), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
        .prdata(rsp.prdata), .pready(rsp.pready), .pslverr(rsp.pslverr),
        .counter_value(cnt.count), .counter_match(cnt.match), .counter_overflow(cnt.overflow),
        .counter_down(cnt.count_down), .center_pwm_select(cnt.center_pwm_select),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .channel_irq(channel_irq));
    tcm_pin_model i_tcm_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));

    task automatic print_verdict;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge core_clk);
        req.penable <= 1'b1;
        @(posedge core_clk);
        while (rsp.pready !== 1'b1 && i < 20) begin
            @(posedge core_clk);
            i++;
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge core_clk);
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [31:0] d);
        apb(1'b1, TCM_ADDR_CTRL, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        exp_q.push_back({1'b0, d});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic drive(input logic v);
        cap = 16'($random(seed));
        cnt.count <= cap;
        ext_level <= v;
        repeat (6) @(posedge core_clk);
    endtask : drive

    task automatic pulse(input logic ov);
        cnt.overflow <= ov;
        cnt.match <= ~ov;
        @(posedge core_clk);
        cnt.overflow <= 1'b0;
        cnt.match <= 1'b0;
        @(posedge core_clk);
    endtask : pulse

    task automatic chk_pin(input logic oe, input logic out, input logic irq);
        pin_q.push_back({oe, out, irq});
        @(posedge core_clk);
    endtask : chk_pin

    always @(negedge core_clk) begin
        if (pin_q.size() > 0) begin
            pin_exp = pin_q.pop_front();
            chk("pin_oe", {32'h0, pin_exp[2]}, {32'h0, pin_oe});
            chk("pin_out", {32'h0, pin_exp[1]}, {32'h0, pin_out});
            chk("channel_irq", {32'h0, pin_exp[0]}, {32'h0, channel_irq});
        end
    end

    always @(posedge core_clk) begin
        if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
            chk("prdata", exp_q.pop_front(), {rsp.pslverr, rsp.prdata});
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(TCM_ADDR_CTRL, 32'h0000_0000);
        rd(TCM_ADDR_STATUS, 32'h0000_0001);
        exp_q.push_back(33'h1_0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        for (int e = 1; e < 4; e++) begin
            ctl = 32'(e << 2);
            wr(ctl);
            drive(1'b1);
            fl = ctl[2];
            vexp = fl ? cap : vexp;
            rd(TCM_ADDR_CTRL, {24'h0, fl, ctl[6:0]});
            wr(ctl);
            drive(1'b0);
            fl = ctl[3];
            vexp = fl ? cap : vexp;
            rd(TCM_ADDR_CTRL, {24'h0, fl, ctl[6:0]});
            rd(TCM_ADDR_VALUE, {16'h0, vexp});
        end
        wr(32'h0000_00CC);
        chk_pin(1'b0, 1'b0, 1'b1);
        wr(32'h0000_004C);
        rd(TCM_ADDR_CTRL, 32'h0000_00CC);
        drive(1'b1);
        wr(32'h0000_004C);
        rd(TCM_ADDR_CTRL, 32'h0000_00CC);
        wr(32'h0000_004C);
        chk_pin(1'b0, 1'b0, 1'b0);
        rd(TCM_ADDR_CTRL, 32'h0000_004C);
        for (int e = 3; e >= 0; e--) begin
            wr(32'(16 + (e << 2)));
            pulse(1'b0);
            lvl = (e == 3) ? 1'b1 : (e == 2) ? 1'b0 : (e == 1) ? ~lvl : lvl;
            chk_pin(e != 0, (e != 0) && lvl, 1'b0);
        end
        rd(TCM_ADDR_CTRL, 32'h0000_0090);
        rd(TCM_ADDR_STATUS, 32'h0000_0002);
        cap = 16'($random(seed));
        apb(1'b1, TCM_ADDR_VALUE, {16'h0000, cap});
        rd(TCM_ADDR_VALUE, {16'h0000, cap});
        for (int k = 0; k < 2; k++) begin
            ctl = k ? 32'h0000_0034 : 32'h0000_0028;
            wr(ctl);
            pulse(1'b1);
            chk_pin(1'b1, ~ctl[2], 1'b0);
            pulse(1'b0);
            chk_pin(1'b1, ctl[2], 1'b0);
        end
        rd(TCM_ADDR_STATUS, 32'h0000_0004);
        cnt.center_pwm_select <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            ctl = k ? 32'h0000_001C : 32'h0000_0008;
            wr(ctl);
            pulse(1'b0);
            chk_pin(1'b1, ctl[2], 1'b0);
            rd(TCM_ADDR_CTRL, ctl | 32'h80);
            wr(ctl);
            cnt.count_down <= 1'b1;
            pulse(1'b0);
            cnt.count_down <= 1'b0;
            chk_pin(1'b1, ~ctl[2], 1'b0);
            rd(TCM_ADDR_CTRL, ctl | 32'h80);
        end
        rd(TCM_ADDR_STATUS, 32'h0000_0008);
        print_verdict();
    end
endmodule : tb

//--- testbench/tcm_pin_model.sv
// Behavioural model of the channel pin and the outside driver.
`timescale 1ns/1ps
module tcm_pin_model (
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic ext_level,
    output logic pin_in
);
    // The pin shows the channel's drive while enabled and the outside level otherwise.
    assign pin_in = pin_oe ? pin_out : ext_level;
endmodule : tcm_pin_model
